//--- bench/ptm_top_asserts.sv
// bus and flag checks on the periodic timer top ports
// assumes bind onto ptm_top, single clock clk_i
`timescale 1ns/1ps
module ptm_top_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // pin and flags
  input wire logic pin_o,
  input wire logic pin_oe_o,
  input wire logic a_match_flag_o,
  input wire logic period_match_flag_o
);
  logic take;
  logic [1:0] clr_q;
  logic rd_q;
  assign take = cyc_i && stb_i && !ack_o;
  always_ff @(posedge clk_i) begin
    clr_q <= {2{take && we_i && sel_i[0] && adr_i == 8'h28}} & dat_i[1:0];
    rd_q <= take && !we_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_answer;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_answer: assert property (s_take |=> s_answer)
    else $error("ack not one cycle after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(ack_o) |-> $past(take))
    else $error("ack without request");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    !ack_o && !pin_o && !a_match_flag_o && !period_match_flag_o && dat_o == 32'h0)
    else $error("outputs not cleared by reset");
  a_dat_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_dat_hold: assert property ($changed(dat_o) && !$past(rst_i) |-> rd_q)
    else $error("read data changed without read");
  a_aflag_clear: assert property ($fell(a_match_flag_o) && !$past(rst_i) |-> clr_q[0])
    else $error("a flag fell without clear");
  a_pflag_clear: assert property ($fell(period_match_flag_o) && !$past(rst_i) |-> clr_q[1])
    else $error("period flag fell without clear");
endmodule : ptm_top_asserts

bind ptm_top ptm_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .a_match_flag_o(a_match_flag_o),
  .period_match_flag_o(period_match_flag_o));

//--- bench/ptm_top_tb.sv
// self-checking bench for the periodic timer top
// assumes wishbone map of ptm_regs.svh, one tick per clock
`timescale 1ns/1ps
module ptm_top_tb;
  import ptm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd, rd2;
  logic ack_o, pin_o, pin_oe_o, a_match_flag_o, period_match_flag_o;
  int n_mismatch = 0;
  int cmp_count = 0;
  int k, n;
  logic [7:0] c1 [5] = '{8'hA8, 8'hA8, 8'hAC, 8'h98, 8'h88};
  int av [5] = '{1, 4, 1, 1, 1};
  int ex [5] = '{10, 40, 30, 40, 0};
  always #50 clk_i = ~clk_i;
  ptm_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .a_match_flag_o(a_match_flag_o),
    .period_match_flag_o(period_match_flag_o));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (t >= 20) begin
      n_mismatch++;
      end_sim();
    end
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic wait_hi(input bit prd);
    int t;
    for (t = 0; t < 600 && (prd ? period_match_flag_o : a_match_flag_o) !== 1'b1; t++) begin
      @(posedge clk_i);
      #1;
    end
    if ((prd ? period_match_flag_o : a_match_flag_o) !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
  endtask : wait_hi
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (k = 8; k <= 8'h24; k += 4) rdc(k[7:0], 32'h0);
    for (k = 8'h10; k <= 8'h24; k += 4) begin
      wb(1'b1, k[7:0], k + 32'h5A);
      rdc(k[7:0], k + 32'h5A);
    end
    wb(1'b1, 8'h08, 32'hFF);
    rdc(8'h08, 32'h0);
    rdc(8'hFC, 32'h0);
    wb(1'b1, 8'h04, 32'hFF);
    rdc(8'h04, 32'hFD);
    $display("test registers done");
    wb(1'b1, 8'h10, 32'h0);
    wb(1'b1, 8'h14, 32'h1);
    wb(1'b1, 8'h20, 32'h3);
    wb(1'b1, 8'h24, 32'h0);
    wb(1'b1, 8'h04, 32'h39);
    wb(1'b1, 8'h00, 32'h8);
    repeat (2) @(posedge clk_i);
    #1;
    chk(pin_o, 1);
    repeat (20) @(posedge clk_i);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    rd2 = rd;
    rdc(8'h08, rd2);
    chk(rd2 > 32'h10, 1);
    wb(1'b1, 8'h00, 32'h8);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd < 32'h4, 1);
    wb(1'b1, 8'h00, 32'h8);
    wait_hi(1'b0);
    chk(period_match_flag_o, 0);
    @(posedge clk_i);
    #1;
    chk(pin_o, 0);
    $display("test compare clear on a done");
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h28, 32'h3);
    rdc(8'h28, 32'h0);
    wb(1'b1, 8'h10, 32'h0);
    wb(1'b1, 8'h14, 32'h0);
    wb(1'b1, 8'h00, 32'h8);
    repeat (40) @(posedge clk_i);
    #1;
    chk(a_match_flag_o, 0);
    chk(pin_o, 1);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h04, 32'h38);
    wb(1'b1, 8'h10, 32'h2);
    wb(1'b1, 8'h14, 32'h0);
    wb(1'b1, 8'h00, 32'h8);
    wait_hi(1'b1);
    chk(a_match_flag_o, 1);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h04, 32'hF8);
    wb(1'b1, 8'h28, 32'h3);
    wb(1'b1, 8'h00, 32'h8);
    wait_hi(1'b1);
    chk(a_match_flag_o, 1);
    chk(pin_oe_o, 0);
    $display("test compare and timer modes done");
    wb(1'b1, 8'h20, 32'h4);
    for (k = 0; k < 5; k++) begin
      wb(1'b1, 8'h00, 32'h0);
      wb(1'b1, 8'h28, 32'h3);
      wb(1'b1, 8'h04, {24'h0, c1[k]});
      wb(1'b1, 8'h10, av[k]);
      wb(1'b1, 8'h00, 32'h8);
      repeat (8) @(posedge clk_i);
      n = 0;
      repeat (40) begin
        @(posedge clk_i);
        #1;
        n += pin_o;
      end
      chk(n, ex[k]);
      chk(period_match_flag_o, 1);
    end
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h20, 32'h0);
    wb(1'b1, 8'h00, 32'h8);
    repeat (20) @(posedge clk_i);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd > 32'h10, 1);
    $display("test pwm done");
    end_sim();
  end
endmodule : ptm_top_tb

//--- logic/ptm_cnt_if.sv
// carrier between register side and counter core
// assumes one clock domain
`timescale 1ns/1ps
interface ptm_cnt_if;
  import ptm_pkg::*;
  logic enable;
  logic start;
  ptm_mode_t mode;
  logic clear_select;
  ptm_word_t a_val;
  ptm_word_t p_val;
  ptm_word_t count;
  logic a_match;
  logic p_match;
  logic pwm_active;

  modport core (
    input enable, start, mode, clear_select, a_val, p_val,
    output count, a_match, p_match, pwm_active
  );
  modport ctl (
    output enable, start, mode, clear_select, a_val, p_val,
    input count, a_match, p_match, pwm_active
  );
endinterface : ptm_cnt_if

//--- logic/ptm_counter.sv
// 16-bit up-counter with comparators a and period
// assumes enable and start come from the register side, same clock
`timescale 1ns/1ps
`include "ptm_regs.svh"
module ptm_counter
  import ptm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control and result
  ptm_cnt_if.core cnt
);
  ptm_word_t cnt_q;
  ptm_word_t cnt_d;
  ptm_word_t p_term;
  logic a_hit;
  logic p_hit;

  // pwm terminal count is period minus one; zero wraps after 65536
  assign p_term = cnt.p_val - `PTM_WORD_ONE;

  always_comb begin
    a_hit = 1'b0;
    p_hit = 1'b0;
    cnt_d = cnt_q + `PTM_WORD_ONE;
    if (ptm_is_cmp(cnt.mode)) begin
      a_hit = (cnt_q == cnt.a_val) && (cnt.a_val != `PTM_WORD_RST);
      if (cnt.clear_select) begin
        if (a_hit) begin
          cnt_d = `PTM_WORD_RST;
        end
      end else begin
        // an all-zero period matches at the top count, i.e. on overflow
        if (cnt.p_val == `PTM_WORD_RST) begin
          p_hit = (cnt_q == ~`PTM_WORD_RST);
        end else begin
          p_hit = (cnt_q == cnt.p_val);
        end
        if (p_hit) begin
          cnt_d = `PTM_WORD_RST;
        end
      end
    end else if (cnt.mode == PTM_MODE_PWM) begin
      a_hit = (cnt_q == cnt.a_val);
      p_hit = (cnt_q == p_term);
      if (p_hit) begin
        cnt_d = `PTM_WORD_RST;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= `PTM_WORD_RST;
    end else if (cnt.start) begin
      cnt_q <= `PTM_WORD_RST;
    end else if (cnt.enable) begin
      cnt_q <= cnt_d;
    end
  end

  assign cnt.count = cnt_q;
  assign cnt.a_match = cnt.enable && !cnt.start && a_hit;
  assign cnt.p_match = cnt.enable && !cnt.start && p_hit;
  // duty at or above period holds the active level
  assign cnt.pwm_active = (cnt_q < cnt.a_val) ||
                          ((cnt.p_val != `PTM_WORD_RST) && (cnt.a_val >= cnt.p_val));
endmodule : ptm_counter

//--- logic/ptm_pkg.sv
// types shared by the periodic timer modules
// assumes ptm_regs.svh for numeric constants
package ptm_pkg;
  typedef enum logic [1:0] {
    PTM_MODE_CMP = 2'h0,
    PTM_MODE_CAP = 2'h1,
    PTM_MODE_PWM = 2'h2,
    PTM_MODE_TMR = 2'h3
  } ptm_mode_t;

  typedef logic [15:0] ptm_word_t;

  // compare output and timer/counter share counting behaviour
  function automatic logic ptm_is_cmp(input ptm_mode_t m);
    ptm_is_cmp = (m == PTM_MODE_CMP) || (m == PTM_MODE_TMR);
  endfunction : ptm_is_cmp
endpackage : ptm_pkg

//--- logic/ptm_regs.svh
// register map, field positions and codes of the periodic timer
// assumes byte-wide registers, one per aligned 32-bit word
`ifndef PTM_REGS_SVH
`define PTM_REGS_SVH
// byte addresses
`define PTM_ADR_CTRL0 8'h00
`define PTM_ADR_CTRL1 8'h04
`define PTM_ADR_CNT_LO 8'h08
`define PTM_ADR_CNT_HI 8'h0C
`define PTM_ADR_VAL_BASE 8'h10
`define PTM_VAL_STRIDE 8'h08
`define PTM_BYTE_STEP 8'h04
`define PTM_ADR_STATUS 8'h28
// value register indices (a, b, period)
`define PTM_VAL_A 0
`define PTM_VAL_B 1
`define PTM_VAL_P 2
`define PTM_VAL_NUM 3
// field positions
`define PTM_EN_BIT 3
`define PTM_MODE_HI 7
`define PTM_MODE_LO 6
`define PTM_PF_HI 5
`define PTM_PF_LO 4
`define PTM_OC_BIT 3
`define PTM_POL_BIT 2
`define PTM_CLR_BIT 0
`define PTM_AF_BIT 0
`define PTM_PF_FLAG_BIT 1
// writable masks and reset values
`define PTM_CTRL0_MASK 8'h08
`define PTM_CTRL1_MASK 8'hFD
`define PTM_BYTE_RST 8'h00
`define PTM_WORD_RST 16'h0000
`define PTM_WORD_ONE 16'h0001
// pin function codes, compare mode
`define PTM_PF_NONE 2'h0
`define PTM_PF_LOW 2'h1
`define PTM_PF_HIGH 2'h2
`define PTM_PF_TOG 2'h3
// pin function codes, pwm mode
`define PTM_PF_INACT 2'h0
`define PTM_PF_ACT 2'h1
`define PTM_PF_PWM 2'h2
`endif

//--- logic/ptm_top.sv
// periodic timer with compare output, timer/counter and pwm modes
// assumes a classic wishbone master on clk_i; one counter tick per clock
//
// Functional notes
// - counter readable as two read-only bytes
// - compare a value in two bytes
// - capture b value in two bytes
// - period value in two bytes
// - two-bit field selects the operating mode
// - mode 00 is compare output mode
// - clear select low: period clear, both flags
// - clear select high: a clear, a flag only
// - a value zero: overflow, no a flag
// - pin moves only on a match
// - pin function picks low, high, toggle
// - enable rise loads pin initial level
// - mode 11 like compare, pin unused
// - mode 10 pwm: period clears, a duty
// - pwm raises both match flags
// - pwm period equals period value, zero 65536
// - duty at or above period gives 100%
// - pwm level, force and polarity controls
// - pwm counting continues while output forced
// - enable rise zeroes counter, fall holds
// - pin function codes per mode
// - output control: initial level or active level
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "ptm_regs.svh"
module ptm_top
  import ptm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // timer output pin
  output logic pin_o,
  output logic pin_oe_o,
  // match flags
  output logic a_match_flag_o,
  output logic period_match_flag_o
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic ack_q;
  logic req;
  logic wr;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic [7:0] wbyte;

  assign req = cyc_i && stb_i && !ack_q;
  assign wr = req && we_i && sel_i[0];
  assign wbyte = dat_i[7:0];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a[7:2] == b[7:2]);
  endfunction : hit

  // ----------------------------------------------------------------
  // value register addresses
  // ----------------------------------------------------------------
  // three 16-bit values, each a low and a high byte register
  function automatic logic [7:0] val_adr(input int idx, input logic hi_byte);
    val_adr = `PTM_ADR_VAL_BASE + 8'(idx) * `PTM_VAL_STRIDE;
    if (hi_byte) begin
      val_adr = val_adr + `PTM_BYTE_STEP;
    end
  endfunction : val_adr

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] c0_q;
  logic [7:0] c1_q;
  logic en_q;
  logic en_dly_q;
  logic start;
  ptm_mode_t mode;
  logic [1:0] pin_func;
  logic out_ctl;
  logic out_pol;
  logic clr_sel;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c0_q <= `PTM_BYTE_RST;
    end else if (wr && hit(adr_i, `PTM_ADR_CTRL0)) begin
      c0_q <= wbyte & `PTM_CTRL0_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c1_q <= `PTM_BYTE_RST;
    end else if (wr && hit(adr_i, `PTM_ADR_CTRL1)) begin
      c1_q <= wbyte & `PTM_CTRL1_MASK;
    end
  end

  assign en_q = c0_q[`PTM_EN_BIT];
  assign mode = ptm_mode_t'(c1_q[`PTM_MODE_HI:`PTM_MODE_LO]);
  assign pin_func = c1_q[`PTM_PF_HI:`PTM_PF_LO];
  assign out_ctl = c1_q[`PTM_OC_BIT];
  assign out_pol = c1_q[`PTM_POL_BIT];
  assign clr_sel = c1_q[`PTM_CLR_BIT];

  // enable edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_dly_q <= 1'b0;
    end else begin
      en_dly_q <= en_q;
    end
  end

  assign start = en_q && !en_dly_q;

  // ----------------------------------------------------------------
  // compare, capture and period values
  // ----------------------------------------------------------------
  ptm_word_t val_q [`PTM_VAL_NUM];

  // bytes of a value are written independently, effective at once
  generate
    for (genvar gi = 0; gi < `PTM_VAL_NUM; gi++) begin : g_val
      localparam logic [7:0] LO_ADR = val_adr(gi, 1'b0);
      localparam logic [7:0] HI_ADR = val_adr(gi, 1'b1);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          val_q[gi] <= `PTM_WORD_RST;
        end else if (wr && hit(adr_i, LO_ADR)) begin
          val_q[gi][7:0] <= wbyte;
        end else if (wr && hit(adr_i, HI_ADR)) begin
          val_q[gi][15:8] <= wbyte;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // counter core
  // ----------------------------------------------------------------
  ptm_cnt_if cif ();

  assign cif.enable = en_q;
  assign cif.start = start;
  assign cif.mode = mode;
  assign cif.clear_select = clr_sel;
  assign cif.a_val = val_q[`PTM_VAL_A];
  assign cif.p_val = val_q[`PTM_VAL_P];

  ptm_counter u_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cnt(cif.core)
  );

  // ----------------------------------------------------------------
  // match flags
  // ----------------------------------------------------------------
  logic af_q;
  logic pf_q;
  logic af_clr;
  logic pf_clr;
  logic st_wr;

  // write one to clear; a new match in the same cycle wins
  assign st_wr = wr && hit(adr_i, `PTM_ADR_STATUS);
  assign af_clr = st_wr && wbyte[`PTM_AF_BIT];
  assign pf_clr = st_wr && wbyte[`PTM_PF_FLAG_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      af_q <= 1'b0;
    end else begin
      af_q <= (af_q && !af_clr) || cif.a_match;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pf_q <= 1'b0;
    end else begin
      pf_q <= (pf_q && !pf_clr) || cif.p_match;
    end
  end

  assign a_match_flag_o = af_q;
  assign period_match_flag_o = pf_q;

  // ----------------------------------------------------------------
  // compare output pin state
  // ----------------------------------------------------------------
  logic cmp_lvl_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_lvl_q <= 1'b0;
    end else if (start) begin
      cmp_lvl_q <= out_ctl;
    end else if (mode == PTM_MODE_CMP && cif.a_match) begin
      case (pin_func)
        `PTM_PF_LOW: begin
          cmp_lvl_q <= 1'b0;
        end
        `PTM_PF_HIGH: begin
          cmp_lvl_q <= 1'b1;
        end
        `PTM_PF_TOG: begin
          cmp_lvl_q <= !cmp_lvl_q;
        end
        default: begin
          cmp_lvl_q <= cmp_lvl_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pwm level and pin drive
  // ----------------------------------------------------------------
  logic pwm_on;
  logic pin_d;
  logic pin_q;
  logic oe_d;
  logic oe_q;

  always_comb begin
    case (pin_func)
      `PTM_PF_INACT: begin
        pwm_on = 1'b0;
      end
      `PTM_PF_ACT: begin
        pwm_on = 1'b1;
      end
      `PTM_PF_PWM: begin
        pwm_on = cif.pwm_active;
      end
      default: begin
        pwm_on = 1'b0;
      end
    endcase
  end

  always_comb begin
    pin_d = 1'b0;
    oe_d = 1'b0;
    case (mode)
      PTM_MODE_CMP: begin
        pin_d = cmp_lvl_q ^ out_pol;
        oe_d = 1'b1;
      end
      PTM_MODE_PWM: begin
        // active level from output control, then polarity
        pin_d = (pwm_on ? out_ctl : !out_ctl) ^ out_pol;
        oe_d = 1'b1;
      end
      PTM_MODE_TMR: begin
        pin_d = 1'b0;
        oe_d = 1'b0;
      end
      default: begin
        pin_d = cmp_lvl_q ^ out_pol;
        oe_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      oe_q <= oe_d;
    end
  end

  assign pin_o = pin_q;
  assign pin_oe_o = oe_q;

  // ----------------------------------------------------------------
  // read mux and acknowledge
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit(adr_i, `PTM_ADR_CTRL0)) begin
      rd_d[7:0] = c0_q;
    end else if (hit(adr_i, `PTM_ADR_CTRL1)) begin
      rd_d[7:0] = c1_q;
    end else if (hit(adr_i, `PTM_ADR_CNT_LO)) begin
      rd_d[7:0] = cif.count[7:0];
    end else if (hit(adr_i, `PTM_ADR_CNT_HI)) begin
      rd_d[7:0] = cif.count[15:8];
    end else if (hit(adr_i, `PTM_ADR_STATUS)) begin
      rd_d[`PTM_AF_BIT] = af_q;
      rd_d[`PTM_PF_FLAG_BIT] = pf_q;
    end else begin
      for (int i = 0; i < `PTM_VAL_NUM; i++) begin
        if (hit(adr_i, val_adr(i, 1'b0))) begin
          rd_d[7:0] = val_q[i][7:0];
        end
        if (hit(adr_i, val_adr(i, 1'b1))) begin
          rd_d[7:0] = val_q[i][15:8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req && !we_i) begin
      dat_q <= rd_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

endmodule : ptm_top
